// ---- rtl/slp_consts.svh ----
`ifndef SLP_CONSTS_SVH
`define SLP_CONSTS_SVH

// Clock period in picoseconds at 200 MHz.
`define SLP_CLK_PERIOD_PS 5000
// Row cycle time in picoseconds.
`define SLP_ROW_CYCLE_TIME_PS 60000
// Input setup time in picoseconds.
`define SLP_INPUT_SETUP_PS 1500
// Self refresh exit delay in cycles, rounded up.
`define SLP_EXIT_DELAY_CYC \
    ((`SLP_ROW_CYCLE_TIME_PS + `SLP_INPUT_SETUP_PS + `SLP_CLK_PERIOD_PS - 1) \
    / `SLP_CLK_PERIOD_PS)
// Read output disable latency in cycles after the mask is sampled.
`define SLP_READ_MASK_LAT 2
// Width of the exit delay counter.
`define SLP_EXIT_CNT_W 5

`endif

// ---- rtl/slp_pkg.sv ----
package slp_pkg;
    // Low power state of the device, one-hot.
    typedef enum logic [3:0] {
        SLP_ACTIVE  = 4'h1,
        SLP_SUSPEND = 4'h2,
        SLP_PWRDN   = 4'h4,
        SLP_SELFREF = 4'h8
    } slp_state_t;
endpackage

// ---- rtl/slp_sync2.sv ----
`timescale 1ns/1ps
// Two flip-flop synchroniser for one level from outside the clock domain.
module slp_sync2 (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Level in and out.
    input  wire logic d,
    output logic      q
);
    logic meta_reg; // First stage, read only by the second.

    // The reset value is high so an idle strobe reads as inactive.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= 1'b1;
            q        <= 1'b1;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ---- rtl/slp_cke_ctrl.sv ----
`timescale 1ns/1ps
`include "slp_consts.svh"

module slp_cke_ctrl (
    // Clock and synchronous reset.
    input  wire logic clk,
    input  wire logic rst,
    // Command pins from the controller: active low strobes, then clock enable and mask.
    input  wire logic cs_n,
    input  wire logic ras_n,
    input  wire logic cas_n,
    input  wire logic we_n,
    input  wire logic cke,
    input  wire logic dqm,
    // Core status: a burst is running, a read burst is driving data.
    input  wire logic burst_active,
    input  wire logic read_active,
    // Outputs to the core.
    output logic      int_clk_en_reg,
    output logic      cmd_valid_reg,
    output logic      wr_mask_reg,
    output logic      rd_oe_reg,
    output logic      in_buf_en_reg,
    output logic      self_ref_reg,
    output logic      exit_busy_reg
);
    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // All pins cross two flip-flops before decode, so decode lags pins by two cycles.
    logic cs_n_s, ras_n_s, cas_n_s, we_n_s, cke_s, dqm_s;
    logic cke_d_reg; // Clock enable one cycle earlier.

    slp_sync2 u_cs  (.clk(clk), .rst(rst), .d(cs_n),  .q(cs_n_s));
    slp_sync2 u_ras (.clk(clk), .rst(rst), .d(ras_n), .q(ras_n_s));
    slp_sync2 u_cas (.clk(clk), .rst(rst), .d(cas_n), .q(cas_n_s));
    slp_sync2 u_we  (.clk(clk), .rst(rst), .d(we_n),  .q(we_n_s));
    slp_sync2 u_cke (.clk(clk), .rst(rst), .d(cke),   .q(cke_s));
    slp_sync2 u_dqm (.clk(clk), .rst(rst), .d(dqm),   .q(dqm_s));

    // ****************************************************************
    // Command decode
    // ****************************************************************
    slp_pkg::slp_state_t state_reg, state_next;
    logic [`SLP_EXIT_CNT_W-1:0] exit_cnt_reg, exit_cnt_next;
    logic [`SLP_READ_MASK_LAT-1:0] rd_mask_pipe_reg; // Read mask delay line.

    wire selected   = ~cs_n_s; // Deselect ignores strobes.
    wire is_nop     = selected & ras_n_s & cas_n_s & we_n_s;
    wire sr_entry   = selected & ~ras_n_s & ~cas_n_s & we_n_s
                      & ~cke_s & cke_d_reg;
    // A fall counts only after a cycle with clock enable high, so staying low never re-enters.
    wire cke_fall   = cke_d_reg & ~cke_s;
    // Commands and entries are honoured only while fully awake.
    wire is_active  = (state_reg == slp_pkg::SLP_ACTIVE);

    // ****************************************************************
    // Low power state machine
    // ****************************************************************
    // Self refresh entry wins over suspend and power-down on the same edge.
    always_comb begin
        state_next    = state_reg;
        exit_cnt_next = (exit_cnt_reg != '0) ? exit_cnt_reg - 1'b1 : exit_cnt_reg;
        unique case (state_reg)
            slp_pkg::SLP_ACTIVE: begin
                if (sr_entry) begin
                    state_next = slp_pkg::SLP_SELFREF;
                end else if (cke_fall && burst_active) begin
                    state_next = slp_pkg::SLP_SUSPEND;
                end else if (cke_fall) begin
                    state_next = slp_pkg::SLP_PWRDN;
                end
            end
            slp_pkg::SLP_SUSPEND: begin
                if (cke_s) begin
                    state_next = slp_pkg::SLP_ACTIVE;
                end
            end
            slp_pkg::SLP_PWRDN: begin
                if (cke_s) begin
                    state_next = slp_pkg::SLP_ACTIVE;
                end
            end
            slp_pkg::SLP_SELFREF: begin
                // Only clock enable is watched here.
                if (cke_s) begin
                    state_next    = slp_pkg::SLP_ACTIVE;
                    exit_cnt_next = `SLP_EXIT_CNT_W'(`SLP_EXIT_DELAY_CYC);
                end
            end
            default: state_next = slp_pkg::SLP_ACTIVE;
        endcase
    end

    // State, counter and history registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= slp_pkg::SLP_ACTIVE;
            exit_cnt_reg <= '0;
            cke_d_reg    <= 1'b1;
        end else begin
            state_reg    <= state_next;
            exit_cnt_reg <= exit_cnt_next;
            cke_d_reg    <= cke_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // The internal clock runs only in the active state, so a suspended burst keeps its state.
    wire next_active = (state_next == slp_pkg::SLP_ACTIVE);
    wire next_pwrdn  = (state_next == slp_pkg::SLP_PWRDN)
                       | (state_next == slp_pkg::SLP_SELFREF);

    // Output registers, all driven from reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            int_clk_en_reg   <= 1'b1;
            cmd_valid_reg    <= 1'b0;
            wr_mask_reg      <= 1'b1;
            rd_oe_reg        <= 1'b0;
            in_buf_en_reg    <= 1'b1;
            self_ref_reg     <= 1'b0;
            exit_busy_reg    <= 1'b0;
            rd_mask_pipe_reg <= '1;
        end else begin
            int_clk_en_reg   <= next_active;
            // A command counts only when active and not a NOP.
            cmd_valid_reg    <= is_active & selected & ~is_nop & cke_s;
            wr_mask_reg      <= dqm_s; // Same cycle as the data word.
            rd_mask_pipe_reg <= {rd_mask_pipe_reg[`SLP_READ_MASK_LAT-2:0], dqm_s};
            rd_oe_reg        <= read_active & ~rd_mask_pipe_reg[`SLP_READ_MASK_LAT-1]
                                & ~next_pwrdn;
            in_buf_en_reg    <= ~next_pwrdn;
            self_ref_reg     <= (state_next == slp_pkg::SLP_SELFREF);
            exit_busy_reg    <= (exit_cnt_next != '0);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Every property but lowpow_cmd_a watches the synchronised pins, so each one speaks of decode time,
    // not of the pin edge; reset disables them all.
    sr_entry_go_a: assert property (@(posedge clk) disable iff (rst)
        (is_active && sr_entry) |=> self_ref_reg)
        else $error("self refresh entry not taken");

    sr_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == slp_pkg::SLP_SELFREF && !cke_s) |=> self_ref_reg)
        else $error("self refresh left with clock enable low");

    suspend_clk_a: assert property (@(posedge clk) disable iff (rst)
        (is_active && cke_fall && burst_active && !sr_entry) |=> !int_clk_en_reg)
        else $error("clock not suspended during burst");

    pwrdn_buf_a: assert property (@(posedge clk) disable iff (rst)
        (is_active && cke_fall && !burst_active) |=> (!in_buf_en_reg && !rd_oe_reg))
        else $error("buffers on in power-down");

    resume_clk_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == slp_pkg::SLP_SUSPEND && cke_s) |=> int_clk_en_reg)
        else $error("clock not restarted");

    pwrdn_exit_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == slp_pkg::SLP_PWRDN && cke_s) |=> in_buf_en_reg)
        else $error("buffers not re-enabled");

    exit_delay_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg == slp_pkg::SLP_SELFREF && cke_s)
            |=> exit_busy_reg [*8] ##1 exit_busy_reg [*5] ##1 !exit_busy_reg)
        else $error("exit delay not thirteen cycles long");

    wr_mask_a: assert property (@(posedge clk) disable iff (rst)
        dqm_s |=> wr_mask_reg)
        else $error("write mask lost");

    rd_mask_a: assert property (@(posedge clk) disable iff (rst)
        dqm_s |-> ##3 !rd_oe_reg)
        else $error("read output not disabled two cycles after mask");

    deselect_a: assert property (@(posedge clk) disable iff (rst)
        cs_n_s |=> !cmd_valid_reg)
        else $error("command taken while deselected");

    // A selected no-operation must never count as a command.
    nop_ignore_a: assert property (@(posedge clk) disable iff (rst)
        (is_nop && cke_s) |=> !cmd_valid_reg)
        else $error("no-operation taken as a command");

    // Auto refresh keeps clock enable high and must not fall into self refresh.
    auto_ref_a: assert property (@(posedge clk) disable iff (rst)
        (is_active && selected && !ras_n_s && !cas_n_s && we_n_s && cke_s) |=> !self_ref_reg)
        else $error("self refresh entered with clock enable high");

    // With no burst running and no self refresh entry, a falling clock enable must land in power-down.
    pwrdn_enter_a: assert property (@(posedge clk) disable iff (rst)
        (is_active && cke_fall && !burst_active && !sr_entry)
            |=> (state_reg == slp_pkg::SLP_PWRDN))
        else $error("power-down not entered");

    // Outside the active state no command counts and only clock enable moves the state.
    lowpow_cmd_a: assert property (@(posedge clk) disable iff (rst)
        (state_reg != slp_pkg::SLP_ACTIVE) |=> !cmd_valid_reg)
        else $error("command taken in a low power state");
endmodule

// ---- tb/slp_ctl_model.sv ----
`timescale 1ns/1ps
// Memory controller model; it moves pins only just after a rising edge.
module slp_ctl_model (
    // Clock and the pins toward the device.
    input  wire logic clk,
    output logic      cs_n,
    output logic      ras_n,
    output logic      cas_n,
    output logic      we_n,
    output logic      cke,
    output logic      dqm
);
    // Power-up state is a deselect with clock enable and mask high.
    initial {cs_n, ras_n, cas_n, we_n, cke, dqm} = 6'h3F;
    // No refreshes go out in bursts, so none are owed around self refresh.
    task automatic drive(input logic [3:0] c, input logic k, input logic m); // c is cs to we.
        @(posedge clk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        {cke, dqm} <= {k, m};
    endtask
    // In self refresh only clock enable moves the state, so the rest flip every cycle.
    task automatic wander(input int n);
        repeat (n) begin
            @(posedge clk);
            {cs_n, ras_n, cas_n, we_n, dqm} <= ~{cs_n, ras_n, cas_n, we_n, dqm};
        end
    endtask
endmodule

// ---- tb/slp_cke_ctrl_tb.sv ----
`timescale 1ns/1ps
module slp_cke_ctrl_tb;
    // Clock, reset and core status; inputs change only at rising edges.
    logic       clk          = 1'b0;
    logic       rst          = 1'b1;
    logic       burst_active = 1'b0, read_active = 1'b0;
    // Pins, and outputs from clock enable down to exit delay in port order.
    wire        cs_n, ras_n, cas_n, we_n, cke, dqm;
    wire  [6:0] o;
    int         err_count    = 0, n_compared = 0;
    // Half period of 2.5 ns.
    always #2.5 clk = ~clk;
    slp_ctl_model slp_ctl_model_inst (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .cke(cke), .dqm(dqm));
    slp_cke_ctrl slp_cke_ctrl_inst (.clk(clk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .cke(cke), .dqm(dqm), .burst_active(burst_active),
        .read_active(read_active), .int_clk_en_reg(o[6]), .cmd_valid_reg(o[5]),
        .wr_mask_reg(o[4]), .rd_oe_reg(o[3]), .in_buf_en_reg(o[2]), .self_ref_reg(o[1]),
        .exit_busy_reg(o[0]));
    // Count one comparison and report a mismatch; an unknown bit fails too.
    task automatic cmp(input logic [6:0] seen, input logic [6:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t: saw %b, expected %b", $time, seen, exp);
        end
    endtask
    // Wait n edges and let them land, then compare the outputs that care selects.
    task automatic check(input int n, input logic [6:0] exp, input logic [6:0] care);
        repeat (n) @(posedge clk);
        #1;
        cmp(o & care, exp & care);
    endtask
    // Print the counts and the verdict, then stop.
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // The run needs about 100 cycles, so a thousand means a hang.
    initial begin
        repeat (1000) @(posedge clk);
        err_count++;
        final_report();
    end
    // Only a selected command that is not a NOP decodes.
    task automatic t_cmd();
        logic [4:0] tab [5] = '{5'h07, 5'h10, 5'h03, 5'h0E, 5'h01};
        foreach (tab[i]) begin
            slp_ctl_model_inst.drive(tab[i][4:1], 1'b1, 1'b0);
            check(3, tab[i][0] ? 7'h64 : 7'h44, 7'h7F);
        end
    endtask
    // Self refresh entry, pins wandering inside, exit and the 13-cycle exit delay.
    task automatic t_selfref();
        slp_ctl_model_inst.drive(4'h1, 1'b0, 1'b0);
        check(3, 7'h02, 7'h6F);
        slp_ctl_model_inst.wander(8);
        check(3, 7'h02, 7'h6F);
        slp_ctl_model_inst.drive(4'h7, 1'b1, 1'b0);
        check(3, 7'h45, 7'h6F);
        check(12, 7'h45, 7'h6F);
        check(1, 7'h44, 7'h6F);
    endtask
    // Clock enable low in a burst suspends; with banks idle it powers down.
    task automatic t_lowpow();
        @(posedge clk);
        burst_active <= 1'b1;
        slp_ctl_model_inst.drive(4'h7, 1'b0, 1'b0);
        check(3, 7'h04, 7'h7F);
        slp_ctl_model_inst.drive(4'h7, 1'b1, 1'b0);
        check(2, 7'h04, 7'h7F);
        check(1, 7'h44, 7'h7F);
        @(posedge clk);
        burst_active <= 1'b0;
        slp_ctl_model_inst.drive(4'h7, 1'b0, 1'b0);
        check(3, 7'h00, 7'h2F);
        slp_ctl_model_inst.drive(4'h7, 1'b1, 1'b0);
        check(3, 7'h44, 7'h7F);
    endtask
    // The mask blocks the write word at once but the read output two cycles on.
    task automatic t_mask();
        @(posedge clk);
        read_active <= 1'b1;
        check(4, 7'h4C, 7'h7F);
        slp_ctl_model_inst.drive(4'h7, 1'b1, 1'b1);
        check(3, 7'h5C, 7'h7F);
        check(1, 7'h5C, 7'h7F);
        check(1, 7'h54, 7'h7F);
    endtask
    // A reset taken in self refresh returns every output to its reset level and leaves no false edge behind.
    task automatic t_reset();
        slp_ctl_model_inst.drive(4'h1, 1'b0, 1'b1);
        check(3, 7'h02, 7'h6F);
        @(posedge clk);
        rst <= 1'b1;
        slp_ctl_model_inst.drive(4'h7, 1'b1, 1'b1);
        check(3, 7'h54, 7'h7F);
        @(posedge clk);
        rst <= 1'b0;
        check(1, 7'h54, 7'h7F);
        check(2, 7'h54, 7'h7F);
    endtask
    // Six cycles of reset with its levels checked, then every scenario in turn.
    initial begin
        check(5, 7'h54, 7'h7F);
        @(posedge clk);
        rst <= 1'b0;
        t_cmd();
        t_selfref();
        t_lowpow();
        t_mask();
        t_reset();
        final_report();
    end
endmodule
